/* rtl/imd_pkg.sv */
// Purpose: Shared constants for the input module diagnostic record block
// Assumes: 40 MHz core clock, four input channels
// Notes:   Record byte positions follow the byte order of the diagnostic record
package imd_pkg;
   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int unsigned TICK_PERIOD_NS = 1000;
   localparam int unsigned CLK_PERIOD_NS  = 25;
   localparam int unsigned TICK_CYC       = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [5:0]  TICK_LAST      = 6'(TICK_CYC - 1);

   // ----------------------------------------------------------------------
   // Access forms and addresses
   // ----------------------------------------------------------------------
   localparam logic [1:0]  MODE_RECORD    = 2'h0;
   localparam logic [1:0]  MODE_OBJ_INDEX = 2'h1;
   localparam logic [1:0]  MODE_SUBINDEX  = 2'h2;
   localparam logic [15:0] REC_HEAD       = 16'h0000;
   localparam logic [15:0] REC_FULL       = 16'h0001;
   localparam logic [15:0] OBJ_HEAD       = 16'h2f00;
   localparam logic [15:0] OBJ_FULL       = 16'h2f01;
   localparam logic [15:0] OBJ_SUB_DIAG   = 16'h5005;
   localparam logic [15:0] OBJ_SUB_PROC   = 16'h5000;
   localparam logic [15:0] OBJ_DIAG_EN    = 16'h3100;
   localparam logic [15:0] OBJ_RISE_MASK  = 16'h3105;
   localparam logic [15:0] OBJ_FALL_MASK  = 16'h3106;
   localparam logic [7:0]  SUB_FIRST      = 8'h02;
   localparam logic [7:0]  SUB_LAST_BYTE  = 8'h11;
   localparam logic [7:0]  SUB_DIAG_TS    = 8'h13;
   localparam logic [7:0]  SUB_PROC_TS_HI = 8'h04;
   localparam logic [7:0]  SUB_PROC_TS_LO = 8'h05;

   // ----------------------------------------------------------------------
   // Record layout
   // ----------------------------------------------------------------------
   localparam logic [4:0]  HEAD_LEN       = 5'd4;
   localparam logic [4:0]  REC_LEN        = 5'd20;
   localparam logic [4:0]  BYTE_TS        = 5'd16;
   localparam logic [4:0]  BYTE_LAST      = 5'd19;
   localparam logic [1:0]  TS_LAST_BYTE   = 2'd3;
   localparam int unsigned FAULT_MODULE   = 0;
   localparam int unsigned FAULT_EXTERNAL = 2;
   localparam int unsigned FAULT_CHANNEL  = 3;
   localparam int unsigned INT_OVERFLOW   = 3;
   localparam int unsigned INT_PROC_LOST  = 6;
   localparam logic [7:0]  CLASS_INFO     = 8'h1f;
   localparam logic [7:0]  KIND_DIG_IN    = 8'h70;
   localparam logic [7:0]  BITS_PER_CH    = 8'h00;
   localparam logic [7:0]  CH_COUNT       = 8'h04;
   localparam logic [7:0]  DIAG_EN_ON     = 8'h40;
   localparam logic [7:0]  RESET_BYTE     = 8'h00;

   typedef enum logic [0:0] {
      IMD_DIAG_IDLE   = 1'b0,
      IMD_DIAG_ACTIVE = 1'b1
   } imd_diag_e;
endpackage : imd_pkg

/* rtl/imd_diag_record.sv */
// Purpose: Microsecond ticker, edge interrupts, diagnostic interrupts and record readout
// Assumes: Inputs and fault pins are asynchronous; requests come from core_clk logic
// Notes:   Reads answer one cycle after the request
`timescale 1ns/1ps
module imd_diag_record
   import imd_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic [3:0]  input_channel,
   input  wire logic        module_fault,
   input  wire logic        external_fault,
   input  wire logic        proc_ack,
   input  wire logic        wr_req,
   input  wire logic [15:0] wr_index,
   input  wire logic [7:0]  wr_data,
   input  wire logic        rd_req,
   input  wire logic [1:0]  rd_mode,
   input  wire logic [15:0] rd_addr,
   input  wire logic [7:0]  rd_sub,
   input  wire logic [4:0]  rd_byte,
   output logic             proc_irq,
   output logic [3:0]       proc_edges,
   output logic [3:0]       proc_state,
   output logic [15:0]      process_irq_timestamp,
   output logic             diag_irq_incoming,
   output logic             diag_irq_going,
   output logic             diag_active,
   output logic             rd_valid,
   output logic             rd_error,
   output logic [7:0]       rd_data
);
   // ----------------------------------------------------------------------
   // Record byte selection
   // ----------------------------------------------------------------------
   function automatic logic [7:0] pick(input logic [159:0] rec, input logic [4:0] idx);
      pick = rec[8*(19-idx) +: 8];
   endfunction : pick

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   logic [5:0]  tick_div;
   logic [31:0] us_count;
   logic [5:0]  sync1;
   logic [5:0]  sync2;
   logic [5:0]  sync3;
   logic [5:0]  clean;
   logic [3:0]  prev_in;
   logic [7:0]  diag_enable;
   logic [3:0]  rising_edge_irq_mask;
   logic [3:0]  falling_edge_irq_mask;
   logic        proc_pending;
   logic [3:0]  lost_edge;
   logic        proc_lost;
   logic        overflow;
   logic [31:0] diag_irq_timestamp;
   imd_diag_e   diag_state;

   // ----------------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------------
   wire         tick_hit   = tick_div == TICK_LAST;
   wire [5:0]   next_clean;
   wire [3:0]   rise       = clean[3:0] & ~prev_in;
   wire [3:0]   fall       = ~clean[3:0] & prev_in;
   wire [3:0]   edges      = (rise & rising_edge_irq_mask) | (fall & falling_edge_irq_mask);
   wire         any_edge   = |edges;
   wire         in_window  = diag_state == IMD_DIAG_ACTIVE;
   wire         edge_take  = any_edge & ~in_window & (~proc_pending | proc_ack);
   wire         edge_lose  = any_edge & ~in_window & proc_pending & ~proc_ack;
   wire         edge_drop  = any_edge & in_window;
   wire         diag_on    = diag_enable == DIAG_EN_ON;
   wire         cause      = (|lost_edge) | proc_lost | overflow | clean[4];
   wire         go_in      = ~in_window & cause & diag_on;
   wire         go_out     = in_window & ~cause;

   // Each status byte is built up from zero, so reserved bits can never leak a one
   wire [7:0] fault_byte  = (8'(clean[4]) << FAULT_MODULE)
                          | (8'(clean[5]) << FAULT_EXTERNAL)
                          | (8'(|lost_edge) << FAULT_CHANNEL);
   wire [7:0] intern_byte = (8'(overflow) << INT_OVERFLOW)
                          | (8'(proc_lost) << INT_PROC_LOST);
   wire [7:0] lost_byte   = {4'h0, lost_edge};
   // Fixed bytes are constants, so no write or reset can disturb them
   wire [159:0] record_bits = {fault_byte,
                               CLASS_INFO,
                               RESET_BYTE,
                               intern_byte,
                               KIND_DIG_IN,
                               BITS_PER_CH,
                               CH_COUNT,
                               lost_byte,
                               {8{RESET_BYTE}},
                               diag_irq_timestamp};

   wire rec_head = rd_mode == MODE_RECORD && rd_addr == REC_HEAD && rd_byte < HEAD_LEN;
   wire rec_full = rd_mode == MODE_RECORD && rd_addr == REC_FULL && rd_byte < REC_LEN;
   wire obj_head = rd_mode == MODE_OBJ_INDEX && rd_addr == OBJ_HEAD && rd_byte < HEAD_LEN;
   wire obj_full = rd_mode == MODE_OBJ_INDEX && rd_addr == OBJ_FULL && rd_byte < REC_LEN;
   wire sub_diag = rd_mode == MODE_SUBINDEX && rd_addr == OBJ_SUB_DIAG;
   wire sub_byte = sub_diag && rd_sub >= SUB_FIRST && rd_sub <= SUB_LAST_BYTE;
   wire sub_ts   = sub_diag && rd_sub == SUB_DIAG_TS && rd_byte <= 5'(TS_LAST_BYTE);
   wire sub_proc = rd_mode == MODE_SUBINDEX && rd_addr == OBJ_SUB_PROC
                   && (rd_sub == SUB_PROC_TS_HI || rd_sub == SUB_PROC_TS_LO);
   wire [4:0] sub_idx = 5'(rd_sub - SUB_FIRST);
   wire [4:0] ts_idx  = BYTE_TS + rd_byte;
   wire [7:0] proc_ts_byte = rd_sub == SUB_PROC_TS_HI ? process_irq_timestamp[15:8]
                                                      : process_irq_timestamp[7:0];
   wire       rd_hit  = rec_head | rec_full | obj_head | obj_full | sub_byte | sub_ts | sub_proc;
   wire [7:0] next_rd_data = sub_proc ? proc_ts_byte :
                             sub_byte ? pick(record_bits, sub_idx) :
                             sub_ts   ? pick(record_bits, ts_idx) :
                             rd_hit   ? pick(record_bits, rd_byte) : RESET_BYTE;
   // Reading the last timestamp byte closes a full readout and releases the flags
   wire       read_done = rd_req & ((rec_full | obj_full) & rd_byte == BYTE_LAST
                                    | sub_ts & rd_byte == 5'(TS_LAST_BYTE));

   // ----------------------------------------------------------------------
   // Microsecond ticker
   // ----------------------------------------------------------------------
   // The count wraps by plain overflow and never stops
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tick_div <= 6'h00;
         us_count <= 32'h0000_0000;
      end else begin
         tick_div <= tick_hit ? 6'h00 : tick_div + 6'h01;
         if (tick_hit) begin
            us_count <= us_count + 32'h0000_0001;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------
   // A change is accepted only once the second and third stages agree
   // Costs four cycles of latency, traded for immunity to metastable glitches
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_sync
         assign next_clean[g] = (sync2[g] == sync3[g]) ? sync3[g] : clean[g];
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sync1   <= 6'h00;
         sync2   <= 6'h00;
         sync3   <= 6'h00;
         clean   <= 6'h00;
         prev_in <= 4'h0;
      end else begin
         sync1   <= {external_fault, module_fault, input_channel};
         sync2   <= sync1;
         sync3   <= sync2;
         clean   <= next_clean;
         prev_in <= clean[3:0];
      end
   end

   // ----------------------------------------------------------------------
   // Parameter writes
   // ----------------------------------------------------------------------
   // Unknown indices are ignored; any value but 40h leaves diagnostics off
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         diag_enable           <= RESET_BYTE;
         rising_edge_irq_mask  <= 4'h0;
         falling_edge_irq_mask <= 4'h0;
      end else if (wr_req) begin
         if (wr_index == OBJ_DIAG_EN) begin
            diag_enable <= wr_data;
         end
         if (wr_index == OBJ_RISE_MASK) begin
            rising_edge_irq_mask <= wr_data[3:0];
         end
         if (wr_index == OBJ_FALL_MASK) begin
            falling_edge_irq_mask <= wr_data[3:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Process interrupts
   // ----------------------------------------------------------------------
   // One interrupt is held until acknowledged; a further edge meanwhile is lost
   // Edges inside a diagnostic window are dropped, never queued
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         proc_irq              <= 1'b0;
         proc_pending          <= 1'b0;
         proc_edges            <= 4'h0;
         proc_state            <= 4'h0;
         process_irq_timestamp <= 16'h0000;
      end else begin
         proc_irq <= edge_take;
         if (edge_take) begin
            proc_pending          <= 1'b1;
            proc_edges            <= edges;
            proc_state            <= clean[3:0];
            process_irq_timestamp <= us_count[15:0];
         end else if (proc_ack) begin
            proc_pending <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Diagnostic flags
   // ----------------------------------------------------------------------
   // Setting beats the release by a completed readout in the same cycle
   // Flags live until the last record byte has been read out
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         lost_edge <= 4'h0;
         proc_lost <= 1'b0;
         overflow  <= 1'b0;
      end else begin
         lost_edge <= (read_done ? 4'h0 : lost_edge) | (edge_lose ? edges : 4'h0);
         proc_lost <= (proc_lost & ~read_done) | edge_lose;
         overflow  <= (overflow & ~read_done) | edge_drop;
      end
   end

   // ----------------------------------------------------------------------
   // Diagnostic interrupt sequencing
   // ----------------------------------------------------------------------
   // One window at a time; causes arising while it is open only keep it open
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         diag_state         <= IMD_DIAG_IDLE;
         diag_irq_incoming  <= 1'b0;
         diag_irq_going     <= 1'b0;
         diag_irq_timestamp <= 32'h0000_0000;
      end else begin
         diag_irq_incoming <= go_in;
         diag_irq_going    <= go_out;
         case (diag_state)
            IMD_DIAG_IDLE: begin
               if (go_in) begin
                  diag_state         <= IMD_DIAG_ACTIVE;
                  diag_irq_timestamp <= us_count;
               end
            end
            IMD_DIAG_ACTIVE: begin
               if (go_out) begin
                  diag_state <= IMD_DIAG_IDLE;
               end
            end
            default: begin
               diag_state <= IMD_DIAG_IDLE;
            end
         endcase
      end
   end

   assign diag_active = in_window;

   // ----------------------------------------------------------------------
   // Record readout
   // ----------------------------------------------------------------------
   // Fixed bytes and reserved areas come from constants in record_bits
   // One byte per request, so a full readout costs twenty requests
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rd_valid <= 1'b0;
         rd_error <= 1'b0;
         rd_data  <= RESET_BYTE;
      end else begin
         rd_valid <= rd_req;
         rd_error <= rd_req & ~rd_hit;
         if (rd_req) begin
            rd_data <= next_rd_data;
         end
      end
   end
endmodule : imd_diag_record

/* test/imd_diag_record_assertions.sv */
// Purpose: Port-level checks for the diagnostic record block
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Ticker phase is hidden, so stamp values are judged by the bench
`timescale 1ns/1ps
module imd_diag_record_assertions
   import imd_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        rd_req,
   input wire logic [1:0]  rd_mode,
   input wire logic [15:0] rd_addr,
   input wire logic [4:0]  rd_byte,
   input wire logic        rd_valid,
   input wire logic        rd_error,
   input wire logic [7:0]  rd_data,
   input wire logic        proc_irq,
   input wire logic [3:0]  proc_edges,
   input wire logic [15:0] process_irq_timestamp,
   input wire logic        diag_irq_incoming,
   input wire logic        diag_irq_going,
   input wire logic        diag_active
);
   // ------
   // Checks
   // ------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire rec_full = rd_req && rd_mode == MODE_RECORD && rd_addr == REC_FULL;
   read_answer_a: assert property (rd_req |=> rd_valid)
      else $error("read got no answer one cycle later");
   answer_cause_a: assert property (rd_valid |-> $past(rd_req))
      else $error("answer without a request");
   error_zero_a: assert property (rd_error |-> rd_valid && rd_data == 8'h00)
      else $error("refused read returned data");
   class_byte_a: assert property (rec_full && rd_byte == 5'd1 |=> rd_data == 8'h1f)
      else $error("class byte wrong");
   count_byte_a: assert property (rec_full && rd_byte == 5'd6 |=> rd_data == 8'h04)
      else $error("channel count byte wrong");
   incoming_open_a: assert property (diag_irq_incoming |-> diag_active && !$past(diag_active))
      else $error("incoming pulse without opening the window");
   going_close_a: assert property (diag_irq_going |-> !diag_active && $past(diag_active))
      else $error("going pulse without closing the window");
   window_quiet_a: assert property ($past(diag_active, 2) && $past(diag_active) |-> !proc_irq)
      else $error("process interrupt inside diagnostic window");
   edge_cause_a: assert property (proc_irq |-> proc_edges != 4'h0)
      else $error("process interrupt with no edge");
   stamp_hold_a: assert property (!proc_irq |-> $stable(process_irq_timestamp))
      else $error("process stamp moved without interrupt");
   cover property (proc_irq);
   cover property (diag_irq_incoming);
   cover property (diag_irq_going);
   cover property (rd_error);
endmodule : imd_diag_record_assertions

/* test/imd_coupler_model.sv */
// Purpose: Backplane coupler that writes parameters and reads the record
// Assumes: Requests are one-cycle pulses launched at the falling edge
// Notes:   Released lines are inverted so stale values never look valid
`timescale 1ns/1ps
module imd_coupler_model
   import imd_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rd_valid,
   input  wire logic        rd_error,
   input  wire logic [7:0]  rd_data,
   output logic             wr_req,
   output logic [15:0]      wr_index,
   output logic [7:0]       wr_data,
   output logic             rd_req,
   output logic [1:0]       rd_mode,
   output logic [15:0]      rd_addr,
   output logic [7:0]       rd_sub,
   output logic [4:0]       rd_byte
);
   initial {wr_req, wr_index, wr_data, rd_req, rd_mode, rd_addr, rd_sub, rd_byte} = '0;
   task automatic put(input logic [15:0] idx, input logic [7:0] val);
      @(negedge core_clk);
      {wr_index, wr_data, wr_req} = {idx, val, 1'b1};
      @(negedge core_clk);
      {wr_index, wr_data, wr_req} = {~idx, ~val, 1'b0};
   endtask : put
   task automatic get(input logic [1:0] m, input logic [15:0] a, input logic [7:0] s,
                      input logic [4:0] b, output logic [7:0] d, output logic e);
      @(negedge core_clk);
      {rd_mode, rd_addr, rd_sub, rd_byte, rd_req} = {m, a, s, b, 1'b1};
      // The answer stands for one cycle only, so it is taken before the release
      @(negedge core_clk);
      d = rd_valid === 1'b1 ? rd_data : 8'hxx;
      e = rd_error;
      {rd_mode, rd_addr, rd_sub, rd_byte, rd_req} = {~m, ~a, ~s, ~b, 1'b0};
   endtask : get
endmodule : imd_coupler_model

/* test/tb_top.sv */
// Purpose: Self-checking bench for the diagnostic record block
// Assumes: 40 MHz clock, inputs driven at the falling edge
// Notes:   Ticker rollover needs hours of run time and is left out
`timescale 1ns/1ps
module tb_top
   import imd_pkg::*;
();
   typedef struct {
      logic [1:0] m; logic [15:0] a; logic [7:0] s; logic [4:0] b; logic [7:0] d; logic e;
   } imd_row_s;
   imd_row_s rows [18] = '{
      '{2'h0, 16'h0001, 8'h00, 5'h00, 8'h00, 1'b0}, '{2'h0, 16'h0001, 8'h00, 5'h01, 8'h1f, 1'b0},
      '{2'h0, 16'h0001, 8'h00, 5'h02, 8'h00, 1'b0}, '{2'h0, 16'h0001, 8'h00, 5'h03, 8'h00, 1'b0},
      '{2'h0, 16'h0001, 8'h00, 5'h04, 8'h70, 1'b0}, '{2'h0, 16'h0001, 8'h00, 5'h05, 8'h00, 1'b0},
      '{2'h0, 16'h0001, 8'h00, 5'h06, 8'h04, 1'b0}, '{2'h0, 16'h0001, 8'h00, 5'h0c, 8'h00, 1'b0},
      '{2'h0, 16'h0000, 8'h00, 5'h04, 8'h00, 1'b1}, '{2'h1, 16'h2f00, 8'h00, 5'h01, 8'h1f, 1'b0},
      '{2'h1, 16'h2f00, 8'h00, 5'h04, 8'h00, 1'b1}, '{2'h2, 16'h5005, 8'h08, 5'h00, 8'h04, 1'b0},
      '{2'h2, 16'h5005, 8'h12, 5'h00, 8'h00, 1'b1}, '{2'h0, 16'h0002, 8'h00, 5'h00, 8'h00, 1'b1},
      '{2'h1, 16'h2f01, 8'h00, 5'h04, 8'h70, 1'b0}, '{2'h2, 16'h5000, 8'h04, 5'h00, 8'h00, 1'b0},
      '{2'h2, 16'h5005, 8'h13, 5'h00, 8'h00, 1'b0}, '{2'h2, 16'h5005, 8'h13, 5'h04, 8'h00, 1'b1}};
   logic        core_clk, rst_n, module_fault, external_fault, proc_ack, e, h;
   logic        wr_req, rd_req, proc_irq, diag_irq_incoming, diag_irq_going;
   logic        diag_active, rd_valid, rd_error;
   logic [3:0]  input_channel, proc_edges, proc_state;
   logic [1:0]  rd_mode;
   logic [4:0]  rd_byte;
   logic [7:0]  wr_data, rd_sub, rd_data, d;
   logic [15:0] wr_index, rd_addr, process_irq_timestamp;
   logic [31:0] ts;
   int          miscompares = 0, checks_done = 0, cyc = 0, t0;
   imd_diag_record imd_diag_record_inst (.core_clk(core_clk), .rst_n(rst_n),
      .input_channel(input_channel), .module_fault(module_fault),
      .external_fault(external_fault), .proc_ack(proc_ack), .wr_req(wr_req),
      .wr_index(wr_index), .wr_data(wr_data), .rd_req(rd_req), .rd_mode(rd_mode),
      .rd_addr(rd_addr), .rd_sub(rd_sub), .rd_byte(rd_byte), .proc_irq(proc_irq),
      .proc_edges(proc_edges), .proc_state(proc_state),
      .process_irq_timestamp(process_irq_timestamp), .diag_irq_incoming(diag_irq_incoming),
      .diag_irq_going(diag_irq_going), .diag_active(diag_active), .rd_valid(rd_valid),
      .rd_error(rd_error), .rd_data(rd_data));
   imd_coupler_model imd_coupler_model_inst (.core_clk(core_clk), .rd_valid(rd_valid),
      .rd_error(rd_error), .rd_data(rd_data), .wr_req(wr_req), .wr_index(wr_index),
      .wr_data(wr_data), .rd_req(rd_req), .rd_mode(rd_mode), .rd_addr(rd_addr),
      .rd_sub(rd_sub), .rd_byte(rd_byte));
   initial core_clk = 1'b0;
   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic rd(input logic [4:0] b, input logic [7:0] x);
      imd_coupler_model_inst.get(2'h0, 16'h0001, 8'h00, b, d, e);
      check({e, d}, {1'b0, x});
   endtask : rd
   task automatic wait_on(input int sel);
      h = 1'b0;
      repeat (30) begin
         @(negedge core_clk);
         if ((sel == 0 ? proc_irq : sel == 1 ? diag_irq_incoming : diag_irq_going) === 1'b1) begin
            h = 1'b1;
            break;
         end
      end
   endtask : wait_on
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict
   // ---------------
   // Main sequence
   // ---------------
   initial begin
      {rst_n, input_channel, module_fault, external_fault, proc_ack} = '0;
      repeat (3) @(negedge core_clk);
      rst_n = 1'b1;
      check({proc_irq, diag_active, rd_valid, process_irq_timestamp}, 32'h0);
      foreach (rows[i]) begin
         imd_coupler_model_inst.get(rows[i].m, rows[i].a, rows[i].s, rows[i].b, d, e);
         check({e, d}, {rows[i].e, rows[i].d});
      end
      $display("table test done");
      imd_coupler_model_inst.put(16'h3105, 8'h01);
      input_channel = 4'h1;
      wait_on(0);
      t0 = cyc;
      ts = {16'h0000, process_irq_timestamp};
      check({h, proc_edges, proc_state}, 32'h111);
      proc_ack = 1'b1;
      @(negedge core_clk);
      {proc_ack, input_channel} = 5'h00;
      wait_on(0);
      check(h, 1'b0);
      imd_coupler_model_inst.put(16'h3105, 8'h0f);
      repeat (400) @(negedge core_clk);
      input_channel = 4'h2;
      wait_on(0);
      check(16'(process_irq_timestamp - ts[15:0] + 16'h1 - 16'((cyc - t0) / 40)) <= 16'h2,
            1'b1);
      input_channel = 4'ha;
      repeat (10) @(negedge core_clk);
      check(diag_active, 1'b0);
      rd(5'd7, 8'h08);
      rd(5'd0, 8'h08);
      rd(5'd3, 8'h40);
      proc_ack = 1'b1;
      @(negedge core_clk);
      proc_ack = 1'b0;
      imd_coupler_model_inst.get(2'h0, 16'h0001, 8'h00, 5'd19, d, e);
      rd(5'd7, 8'h00);
      $display("process interrupt test done");
      imd_coupler_model_inst.put(16'h3100, 8'h40);
      {module_fault, external_fault} = 2'b11;
      wait_on(1);
      t0 = cyc;
      check({h, diag_active}, 2'b11);
      rd(5'd0, 8'h05);
      for (int b = 16; b < 20; b++) begin
         imd_coupler_model_inst.get(2'h0, 16'h0001, 8'h00, 5'(b), d, e);
         ts = {ts[23:0], d};
      end
      check(32'(ts + 32'd2 - 32'(t0 / 40)) <= 32'd4, 1'b1);
      input_channel = 4'hb;
      wait_on(0);
      check(h, 1'b0);
      {module_fault, external_fault} = 2'b00;
      repeat (8) @(negedge core_clk);
      imd_coupler_model_inst.get(2'h0, 16'h0001, 8'h00, 5'd19, d, e);
      wait_on(2);
      check({h, diag_active}, 2'b10);
      $display("diagnostic interrupt test done");
      rst_n = 1'b0;
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      check({proc_irq, diag_active, diag_irq_going, process_irq_timestamp}, 32'h0);
      rd(5'd16, 8'h00);
      module_fault = 1'b1;
      wait_on(1);
      check({h, diag_active}, 2'b00);
      rd(5'd0, 8'h01);
      module_fault = 1'b0;
      $display("reset test done");
      give_verdict();
   end
endmodule : tb_top
bind imd_diag_record imd_diag_record_assertions imd_diag_record_assertions_inst (
   .core_clk(core_clk), .rst_n(rst_n), .rd_req(rd_req), .rd_mode(rd_mode),
   .rd_addr(rd_addr), .rd_byte(rd_byte), .rd_valid(rd_valid), .rd_error(rd_error),
   .rd_data(rd_data), .proc_irq(proc_irq), .proc_edges(proc_edges),
   .process_irq_timestamp(process_irq_timestamp), .diag_irq_incoming(diag_irq_incoming),
   .diag_irq_going(diag_irq_going), .diag_active(diag_active));
